/* rtl/sacp_pkg.sv */
// constants, offsets and state types for the step attenuator control port
package sacp_pkg;

  // core and word widths
  localparam int unsigned ATTN_W = 7;
  localparam int unsigned WORD_W = 8;

  // power-up attenuation setting, 31.5 dB in quarter-dB steps
  localparam logic [6:0] PUP_ATTN_CODE = 7'h7e;
  localparam logic [7:0] PUP_WORD      = 8'h7e;

  // clock rate and the direct-mode power-up delay
  localparam int unsigned CLK_MHZ          = 250;
  localparam int unsigned PUP_DELAY_US     = 400;
  localparam int unsigned PUP_DELAY_CYCLES = PUP_DELAY_US * CLK_MHZ;
  localparam int unsigned DLY_W            = 17;

  // last settle count after reset before the synchronised straps are trusted
  localparam logic [1:0] SETTLE_LAST = 2'h2;

  // synchroniser lane positions
  localparam int unsigned SYNC_W     = 11;
  localparam int unsigned SY_MODE    = 0;
  localparam int unsigned SY_STROBE  = 1;
  localparam int unsigned SY_SCLK    = 2;
  localparam int unsigned SY_SDATA   = 3;
  localparam int unsigned SY_PAR_LSB = 4;

  // register map, byte addresses
  localparam int unsigned ADDR_W      = 12;
  localparam logic [11:0] CTRL_OFFS   = 12'h000;
  localparam logic [11:0] STATUS_OFFS = 12'h004;
  localparam logic [11:0] SHIFT_OFFS  = 12'h008;
  localparam logic [11:0] LATCH_OFFS  = 12'h00c;
  localparam logic [11:0] ERR_OFFS    = 12'h010;

  // field positions
  localparam int unsigned CTRL_FORCE_MAX   = 0;
  localparam int unsigned STAT_SERIAL      = 7;
  localparam int unsigned STAT_STROBE      = 8;
  localparam int unsigned STAT_PUP_HOLD    = 9;
  localparam int unsigned STAT_TOP_BIT     = 10;
  localparam int unsigned STAT_SEQ_DONE    = 11;
  localparam int unsigned LATCH_PAR_LSB    = 8;
  localparam int unsigned ERR_TOP_BIT      = 0;
  localparam int unsigned ERR_PAR_IN_SER   = 1;

  // reset values
  localparam logic CTRL_FORCE_MAX_RST = 1'b0;

  typedef enum logic [1:0] {st_settle, st_delay, st_run} sacp_state_t;

endpackage

/* rtl/sacp_sync.sv */
// two-stage synchroniser for the control pins
`timescale 1ns/1ps
`default_nettype none

module sacp_sync (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        clk_en,
  input  wire logic [sacp_pkg::SYNC_W-1:0] async_in,
  output logic      [sacp_pkg::SYNC_W-1:0] sync_out
);

  typedef struct packed {
    logic [sacp_pkg::SYNC_W-1:0] stage1;
    logic [sacp_pkg::SYNC_W-1:0] stage2;
  } sacp_sync_t;

  sacp_sync_t sync_reg;
  sacp_sync_t sync_next;

  // stage1 feeds stage2 only
  always_comb
  begin
    sync_next        = sync_reg;
    sync_next.stage1 = async_in;
    sync_next.stage2 = sync_reg.stage1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_reg <= '0;
    end
    else if (clk_en)
    begin
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg.stage2;

endmodule

`default_nettype wire

/* rtl/sacp_top.sv */
// step attenuator control port: serial and parallel front end with apb status
`timescale 1ns/1ps
`default_nettype none

module sacp_top #(
  parameter int unsigned PUP_DELAY_CYCLES = sacp_pkg::PUP_DELAY_CYCLES
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        clk_en,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [sacp_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        serial_mode_sel,
  input  wire logic                        latch_strobe,
  input  wire logic                        serial_shift_clk,
  input  wire logic                        serial_data_in,
  input  wire logic [sacp_pkg::ATTN_W-1:0] parallel_attn_inputs,
  output logic      [sacp_pkg::ATTN_W-1:0] step_attenuator_code,
  output logic                             power_up_hold
);

  typedef struct packed {
    sacp_pkg::sacp_state_t             state;
    logic [1:0]                        settle_cnt;
    logic [sacp_pkg::DLY_W-1:0]        dly_cnt;
    logic                              sclk_d;
    logic [sacp_pkg::WORD_W-1:0]       shift;
    logic [sacp_pkg::WORD_W-1:0]       ser_latch;
    logic [sacp_pkg::ATTN_W-1:0]       par_latch;
    logic [sacp_pkg::ATTN_W-1:0]       attn;
    logic                              force_max;
    logic                              err_top;
    logic                              err_par;
    logic                              seq_done;
    logic [31:0]                       prdata;
    logic                              pslverr;
  } sacp_regs_t;

  localparam sacp_regs_t REGS_RST = '{
    state:      sacp_pkg::st_settle,
    settle_cnt: 2'h0,
    dly_cnt:    '0,
    sclk_d:     1'b0,
    shift:      sacp_pkg::PUP_WORD,
    ser_latch:  sacp_pkg::PUP_WORD,
    par_latch:  sacp_pkg::PUP_ATTN_CODE,
    attn:       sacp_pkg::PUP_ATTN_CODE,
    force_max:  sacp_pkg::CTRL_FORCE_MAX_RST,
    err_top:    1'b0,
    err_par:    1'b0,
    seq_done:   1'b0,
    prdata:     32'h0000_0000,
    pslverr:    1'b0
  };

  localparam logic [sacp_pkg::DLY_W-1:0] DLY_LAST = sacp_pkg::DLY_W'(PUP_DELAY_CYCLES - 1);

  sacp_regs_t                    regs_reg;
  sacp_regs_t                    regs_next;

  logic [sacp_pkg::SYNC_W-1:0]   pins_sync;
  logic [sacp_pkg::SYNC_W-1:0]   pins_raw;
  logic                          pin_mode;
  logic                          pin_strobe;
  logic                          pin_sclk;
  logic                          pin_sdata;
  logic [sacp_pkg::ATTN_W-1:0]   pin_par;

  logic                          running;
  logic                          sclk_rise;
  logic                          apb_setup;
  logic                          apb_access;
  logic                          apb_write;
  logic                          serial_commit;
  logic                          err_top_clr;
  logic                          err_par_clr;
  logic [31:0]                   rd_data;
  logic                          rd_hit;
  logic                          direct_strap;

  // lane order must match the lane positions in the package
  assign pins_raw = {parallel_attn_inputs, serial_data_in, serial_shift_clk,
                     latch_strobe, serial_mode_sel};

  // every pin crosses two flops before any logic looks at it
  sacp_sync u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .clk_en   (clk_en),
    .async_in (pins_raw),
    .sync_out (pins_sync)
  );

  assign pin_mode   = pins_sync[sacp_pkg::SY_MODE];
  assign pin_strobe = pins_sync[sacp_pkg::SY_STROBE];
  assign pin_sclk   = pins_sync[sacp_pkg::SY_SCLK];
  assign pin_sdata  = pins_sync[sacp_pkg::SY_SDATA];
  // pads carry pull-downs, so an open line arrives here as zero
  assign pin_par    = pins_sync[sacp_pkg::SY_PAR_LSB +: sacp_pkg::ATTN_W];

  // no wait states, but a frozen block must not accept a transfer
  assign pready     = clk_en;
  assign apb_setup  = psel & ~penable;
  assign apb_access = psel & penable;
  assign apb_write  = apb_access & pwrite;

  assign running   = (regs_reg.state == sacp_pkg::st_run);
  // sclk_d resets low like the idle pin, so reset makes no false edge
  // two-flop sampling limits the serial clock to well below pclk
  assign sclk_rise = pin_sclk & ~regs_reg.sclk_d;

  // strobe high with parallel select at power-up marks direct mode
  assign direct_strap = ~pin_mode & pin_strobe;

  // a serial word commits while strobe is high in serial mode
  assign serial_commit = running & pin_strobe & pin_mode;

  assign err_top_clr = apb_write & (paddr == sacp_pkg::ERR_OFFS)
                       & pwdata[sacp_pkg::ERR_TOP_BIT];
  assign err_par_clr = apb_write & (paddr == sacp_pkg::ERR_OFFS)
                       & pwdata[sacp_pkg::ERR_PAR_IN_SER];

  always_comb
  begin
    regs_next = regs_reg;
    rd_data   = 32'h0000_0000;
    rd_hit    = 1'b1;

    // power-up sequencing
    case (regs_reg.state)
      sacp_pkg::st_settle:
      begin
        if (regs_reg.settle_cnt == sacp_pkg::SETTLE_LAST)
        begin
          // strobe high with parallel select marks direct mode
          if (direct_strap)
          begin
            regs_next.state = sacp_pkg::st_delay;
          end
          else
          begin
            regs_next.state = sacp_pkg::st_run;
          end
        end
        else
        begin
          regs_next.settle_cnt = regs_reg.settle_cnt + 2'h1;
        end
      end
      sacp_pkg::st_delay:
      begin
        // hold maximum for the full power-up delay
        if (regs_reg.dly_cnt == DLY_LAST)
        begin
          regs_next.state = sacp_pkg::st_run;
        end
        else
        begin
          regs_next.dly_cnt = regs_reg.dly_cnt + 1'b1;
        end
      end
      sacp_pkg::st_run:
      begin
        regs_next.state = sacp_pkg::st_run;
      end
      default:
      begin
        regs_next.state = sacp_pkg::st_settle;
      end
    endcase

    // serial clock edge found on the pclk side
    regs_next.sclk_d = pin_sclk;

    // shift only while strobe is low, lsb first
    if (running && !pin_strobe && sclk_rise)
    begin
      regs_next.shift = {pin_sdata, regs_reg.shift[sacp_pkg::WORD_W-1:1]};
    end

    // transparent latches follow while strobe is high
    if (running && pin_strobe)
    begin
      if (pin_mode)
      begin
        regs_next.ser_latch = regs_reg.shift;
      end
      else
      begin
        // each line is one binary weight of a quarter dB code
        regs_next.par_latch = pin_par;
      end
    end

    // core stays at maximum until running and while force_max is set, otherwise follows the mode
    if (!running || regs_reg.force_max)
    begin
      regs_next.attn = sacp_pkg::PUP_ATTN_CODE;
    end
    else if (pin_mode)
    begin
      // word value is dB times four; top bit never reaches the core
      regs_next.attn = regs_reg.ser_latch[sacp_pkg::ATTN_W-1:0];
    end
    else
    begin
      regs_next.attn = regs_reg.par_latch;
    end

    // sticky faults; a new event wins over a clear in the same cycle
    if (err_top_clr)
    begin
      regs_next.err_top = 1'b0;
    end
    if (serial_commit && regs_reg.shift[sacp_pkg::WORD_W-1])
    begin
      regs_next.err_top = 1'b1;
    end
    if (err_par_clr)
    begin
      regs_next.err_par = 1'b0;
    end
    if (running && pin_mode && (pin_par != '0))
    begin
      regs_next.err_par = 1'b1;
    end

    // mode switching is safe once a top-bit-zero word is latched
    if (serial_commit && !regs_reg.shift[sacp_pkg::WORD_W-1])
    begin
      regs_next.seq_done = 1'b1;
    end

    // register read decode
    case (paddr)
      sacp_pkg::CTRL_OFFS:
      begin
        rd_data[sacp_pkg::CTRL_FORCE_MAX] = regs_reg.force_max;
      end
      // status shows synced pins, so they lag the pads by two cycles
      sacp_pkg::STATUS_OFFS:
      begin
        rd_data[sacp_pkg::ATTN_W-1:0]    = regs_reg.attn;
        rd_data[sacp_pkg::STAT_SERIAL]   = pin_mode;
        rd_data[sacp_pkg::STAT_STROBE]   = pin_strobe;
        rd_data[sacp_pkg::STAT_PUP_HOLD] = ~running;
        rd_data[sacp_pkg::STAT_TOP_BIT]  = regs_reg.ser_latch[sacp_pkg::WORD_W-1];
        rd_data[sacp_pkg::STAT_SEQ_DONE] = regs_reg.seq_done;
      end
      sacp_pkg::SHIFT_OFFS:
      begin
        rd_data[sacp_pkg::WORD_W-1:0] = regs_reg.shift;
      end
      sacp_pkg::LATCH_OFFS:
      begin
        rd_data[sacp_pkg::WORD_W-1:0] = regs_reg.ser_latch;
        rd_data[sacp_pkg::LATCH_PAR_LSB +: sacp_pkg::ATTN_W] = regs_reg.par_latch;
      end
      sacp_pkg::ERR_OFFS:
      begin
        rd_data[sacp_pkg::ERR_TOP_BIT]    = regs_reg.err_top;
        rd_data[sacp_pkg::ERR_PAR_IN_SER] = regs_reg.err_par;
      end
      default:
      begin
        rd_hit = 1'b0;
      end
    endcase

    // answer is prepared in the setup cycle so prdata comes from a flop
    if (apb_setup)
    begin
      regs_next.pslverr = ~rd_hit;
      if (pwrite)
      begin
        regs_next.prdata = 32'h0000_0000;
      end
      else
      begin
        regs_next.prdata = rd_data;
      end
    end
    else
    begin
      // access ends at this edge, so the answer clears with it
      regs_next.prdata  = 32'h0000_0000;
      regs_next.pslverr = 1'b0;
    end

    // the control register takes written data; the error register only takes write-one clears
    if (apb_write && paddr == sacp_pkg::CTRL_OFFS)
    begin
      regs_next.force_max = pwdata[sacp_pkg::CTRL_FORCE_MAX];
    end
  end

  // clock enable low freezes everything, bus answers included
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      regs_reg <= REGS_RST;
    end
    else if (clk_en)
    begin
      regs_reg <= regs_next;
    end
  end

  assign prdata               = regs_reg.prdata;
  assign pslverr              = regs_reg.pslverr;
  assign step_attenuator_code = regs_reg.attn;
  assign power_up_hold        = ~running;

endmodule

`default_nettype wire

/* sim/sacp_checker.sv */
// concurrent checks on the control port pins and apb side
`timescale 1ns/1ps
`default_nettype none
module sacp_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clk_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        serial_mode_sel,
  input wire logic        latch_strobe,
  input wire logic [6:0]  parallel_attn_inputs,
  input wire logic [6:0]  step_attenuator_code,
  input wire logic        power_up_hold
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  hold_max_a: assert property (power_up_hold |-> step_attenuator_code == 7'h7e)
    else $error("core not at max during hold");
  settle_a: assert property ($rose(presetn) |-> power_up_hold [*2])
    else $error("hold dropped too early");
  // window of 8 covers sync and latch delay
  strobe_low_a:
    assert property ((!latch_strobe && !psel && $stable(serial_mode_sel)) [*8]
      |-> $stable(step_attenuator_code)) else $error("core moved with strobe low");
  direct_a:
    assert property ((latch_strobe && !serial_mode_sel && !power_up_hold && !psel
      && $stable(parallel_attn_inputs)) [*8] |-> step_attenuator_code == parallel_attn_inputs)
    else $error("core not following lines");
  freeze_a: assert property (!clk_en |=> $stable(step_attenuator_code))
    else $error("core moved while frozen");
  ready_a: assert property (pready == clk_en)
    else $error("pready differs from clk_en");
  idle_a: assert property (!psel |-> prdata == 32'h0 && !pslverr)
    else $error("read data outside transfer");
  unmapped_a: assert property (psel && penable && paddr > 12'h010 |-> pslverr)
    else $error("no error on unmapped address");
  mapped_a: assert property (psel && penable && paddr[1:0] == 2'h0 && paddr <= 12'h010
    |-> !pslverr) else $error("error on mapped address");
endmodule
`default_nettype wire

/* sim/sacp_host_model.sv */
// host controller model driving the attenuator control pins
`timescale 1ns/1ps
`default_nettype none
module sacp_host_model #(
  parameter int GAP = 16 // stand-in for the switching rate, shortened for run time
) (
  input  wire logic       pclk,
  output logic            serial_mode_sel,
  output logic            latch_strobe,
  output logic            serial_shift_clk,
  output logic            serial_data_in,
  output logic [6:0]      parallel_attn_inputs
);
  initial
  begin
    serial_mode_sel = 1'b1;
    latch_strobe = 1'b0;
    serial_shift_clk = 1'b0;
    serial_data_in = 1'b0;
    parallel_attn_inputs = 7'h00; // lines low in serial mode
  end
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic set_pins(input logic m, input logic s, input logic [6:0] p);
    serial_mode_sel <= m;
    latch_strobe <= s;
    parallel_attn_inputs <= p; // lines low before serial
    tick(4);
  endtask
  // 48 ns clock, runs only inside the frame; data inverted once its hold is over
  task automatic shift_word(input logic [7:0] w); // lsb first, strobe low
    for (int i = 0; i < 8; i++)
    begin
      serial_data_in <= w[i];
      tick(4);
      serial_shift_clk <= 1'b1;
      tick(4);
      serial_data_in <= ~w[i];
      tick(2);
      serial_shift_clk <= 1'b0;
      tick(2);
    end
  endtask
  task automatic pulse();
    latch_strobe <= 1'b1;
    tick(6);
    latch_strobe <= 1'b0;
    tick(GAP);
  endtask
endmodule
`default_nettype wire

/* sim/sacp_top_bench.sv */
// self-checking bench for the step attenuator control port
`timescale 1ns/1ps
`default_nettype none
module step_attenuator_control_port_bench;
  logic        pclk;
  logic        presetn;
  logic        clk_en;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        mode;
  logic        strobe;
  logic        sclk;
  logic        sdata;
  logic [6:0]  par;
  logic [6:0]  code;
  logic        hold;
  logic [31:0] rd;
  logic        err;
  int          bad_count = 0;
  int          n_checks = 0;
  sacp_top #(.PUP_DELAY_CYCLES(20)) dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_mode_sel(mode),
    .latch_strobe(strobe), .serial_shift_clk(sclk), .serial_data_in(sdata),
    .parallel_attn_inputs(par), .step_attenuator_code(code), .power_up_hold(hold));
  sacp_host_model host (.pclk(pclk), .serial_mode_sel(mode), .latch_strobe(strobe),
    .serial_shift_clk(sclk), .serial_data_in(sdata), .parallel_attn_inputs(par));
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic print_verdict();
    if (bad_count == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk_word(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic chk_code(input logic [6:0] exp); // bounded wait, then compare
    for (int n = 0; n < 80 && code !== exp; n++)
      @(posedge pclk);
    chk_word("core code", {25'h0, exp}, {25'h0, code});
    if (code !== exp)
    begin
      print_verdict();
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
    begin
      bad_count++;
      print_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic do_reset(input logic m, input logic s, input logic [6:0] p);
    @(posedge pclk);
    presetn <= 1'b0;
    host.set_pins(m, s, p);
    @(posedge pclk);
    presetn <= 1'b1;
  endtask
  task automatic t_serial();
    logic [7:0] w[4] = '{8'h32, 8'h7f, 8'h01, 8'h40};
    do_reset(1'b1, 1'b0, 7'h00);
    host.tick(30);
    chk_word("hold", 32'h0, {31'h0, hold});
    chk_code(7'h7e);
    foreach (w[i])
    begin
      host.shift_word(w[i]);
      chk_word("before latch", {25'h0, i == 0 ? 7'h7e : w[i - 1][6:0]}, {25'h0, code});
      host.pulse();
      chk_code(w[i][6:0]);
    end
    host.shift_word(8'hb2);
    host.pulse();
    chk_code(7'h32);
    apb(1'b0, 12'h010, 32'h0);
    chk_word("top bit flag", 32'h1, rd);
    apb(1'b1, 12'h010, 32'h1);
    host.shift_word(8'h05);
    host.pulse();
    apb(1'b0, 12'h004, 32'h0);
    chk_word("status", 32'h885, {20'h0, rd[11:0]});
  endtask
  task automatic t_latched();
    logic [6:0] p;
    for (int i = 0; i < 8; i++)
    begin
      p = (i < 7) ? 7'(1 << i) : 7'h7f;
      host.set_pins(1'b0, 1'b0, p);
      host.pulse();
      chk_code(p);
      host.set_pins(1'b0, 1'b0, ~p);
      host.tick(12);
      chk_code(p);
    end
    host.set_pins(1'b0, 1'b0, 7'h00);
    host.set_pins(1'b1, 1'b0, 7'h00);
    chk_code(7'h05);
  endtask
  task automatic t_apb();
    apb(1'b1, 12'h000, 32'h1);
    chk_code(7'h7e);
    apb(1'b0, 12'h000, 32'h0);
    chk_word("ctrl", 32'h1, rd);
    apb(1'b0, 12'h100, 32'h0);
    chk_word("unmapped", 32'h1, {31'h0, err});
    apb(1'b1, 12'h000, 32'h0);
    chk_code(7'h05);
    @(posedge pclk);
    clk_en <= 1'b0;
    host.shift_word(8'h11);
    host.pulse();
    clk_en <= 1'b1;
    host.tick(12);
    chk_code(7'h05);
    apb(1'b0, 12'h008, 32'h0);
    chk_word("frozen shift", 32'h05, rd);
  endtask
  task automatic t_direct(input logic [6:0] p);
    do_reset(1'b0, 1'b1, p);
    host.tick(8);
    chk_word("hold", 32'h1, {31'h0, hold});
    chk_word("delay code", 32'h7e, {25'h0, code});
    chk_code(p);
    host.set_pins(1'b0, 1'b1, p ^ 7'h2a);
    chk_code(p ^ 7'h2a);
  endtask
  task automatic t_latched_pup();
    do_reset(1'b0, 1'b0, 7'h2a);
    host.tick(30);
    chk_word("latched pup", 32'h7e, {25'h0, code});
    host.pulse();
    chk_code(7'h2a);
  endtask
  initial
  begin
    presetn = 1'b0;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    t_serial();
    t_latched();
    t_apb();
    t_direct(7'h55);
    t_direct(7'h00);
    t_latched_pup();
    print_verdict();
  end
endmodule
bind sacp_top sacp_checker chk (.*);
`default_nettype wire
